// ### rtl/lirq_ctrl.sv
`default_nettype none
// Functional notes
// - ten-bit full-power recal time in bits 9:0, resets to 3FF, host writable.
// - six-bit low-power recal time in bits 15:10, resets to 3F, host writable.
// - twelve stage enables; enabled low-threshold event asserts the interrupt output.
// - a cleared enable keeps that stage's event off the interrupt output.
// - all twelve stage enables reset to zero.
// - pin function 00 disables the pin, 01 makes it an input.
// - pin function 10 drives active-low output, 11 active-high output.
// - trigger 00 is negative level, 11 is positive level.
// - trigger 01 is rising edge, 10 is falling edge.
// - pin function and trigger fields reset to zero.
module lirq_ctrl
    import lirq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [DATA_WIDTH-1:0] reg_rdata,
    input wire logic [NUM_STAGES-1:0] stage_low_event,
    output logic int_n,
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe,
    input wire logic gpio_assert,
    output logic gpio_event,
    output logic [9:0] full_power_recal_time,
    output logic [5:0] low_power_recal_time
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [9:0] full_power_recal_time;
        logic [5:0] low_power_recal_time;
        logic [NUM_STAGES-1:0] stage_low_threshold_irq_en;
        logic [1:0] pin_func;
        logic [1:0] pin_trig;
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic [DATA_WIDTH-1:0] rdata;
        logic int_n;
        logic gpio_event;
    } lirq_state_type;

    lirq_state_type st;
    lirq_state_type next_st;

    function automatic logic trig_hit(input logic [1:0] trig, input logic now, input logic prev);
        case (trig)
            PIN_TRIG_NEG_LEVEL: trig_hit = !now;
            PIN_TRIG_POS_EDGE: trig_hit = now && !prev;
            PIN_TRIG_NEG_EDGE: trig_hit = !now && prev;
            default: trig_hit = now;
        endcase
    endfunction : trig_hit

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        // pin passes two flops before any logic looks at it
        next_st.pin_meta = gpio_in;
        next_st.pin_sync = st.pin_meta;
        next_st.pin_prev = st.pin_sync;
        if (reg_wr) begin
            if (reg_addr == PROXIMITY_RECAL_TIME_CONTROL_OFFSET) begin
                next_st.full_power_recal_time = reg_wdata[FULL_POWER_RECAL_MSB:FULL_POWER_RECAL_LSB];
                next_st.low_power_recal_time = reg_wdata[LOW_POWER_RECAL_MSB:LOW_POWER_RECAL_LSB];
            end else if (reg_addr == LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET) begin
                next_st.stage_low_threshold_irq_en = reg_wdata[STAGE_EN_MSB:STAGE_EN_LSB];
                next_st.pin_func = reg_wdata[PIN_FUNC_MSB:PIN_FUNC_LSB];
                next_st.pin_trig = reg_wdata[PIN_TRIG_MSB:PIN_TRIG_LSB];
            end
        end
        if (reg_rd) begin
            // unmapped offsets read as zero; a same-cycle write is not yet visible
            if (reg_addr == PROXIMITY_RECAL_TIME_CONTROL_OFFSET) begin
                next_st.rdata = {st.low_power_recal_time, st.full_power_recal_time};
            end else if (reg_addr == LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET) begin
                next_st.rdata = {st.pin_trig, st.pin_func, st.stage_low_threshold_irq_en};
            end else begin
                next_st.rdata = 16'h0000;
            end
        end
        // no latch: the line follows the sources, the host clears them at their origin
        next_st.int_n = !(|(st.stage_low_threshold_irq_en & stage_low_event));
        next_st.gpio_event = (st.pin_func == PIN_FUNC_INPUT)
            && trig_hit(st.pin_trig, st.pin_sync, st.pin_prev);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
            st.full_power_recal_time <= FULL_POWER_RECAL_RESET;
            st.low_power_recal_time <= LOW_POWER_RECAL_RESET;
            st.stage_low_threshold_irq_en <= STAGE_EN_RESET;
            st.pin_func <= PIN_FUNC_DISABLED;
            st.pin_trig <= PIN_TRIG_NEG_LEVEL;
            st.int_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = st.rdata;
    assign int_n = st.int_n;
    assign gpio_event = st.gpio_event;
    assign full_power_recal_time = st.full_power_recal_time;
    assign low_power_recal_time = st.low_power_recal_time;
    assign gpio_oe = st.pin_func[1];
    assign gpio_out = (st.pin_func == PIN_FUNC_OUT_HIGH) ? gpio_assert : !gpio_assert;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_fp_write;
        reg_wr && reg_addr == PROXIMITY_RECAL_TIME_CONTROL_OFFSET |=>
            full_power_recal_time == $past(reg_wdata[9:0]);
    endproperty
    a_fp_write: assert property (p_fp_write) else $error("full power recal not written");

    property p_lp_write;
        reg_wr && reg_addr == PROXIMITY_RECAL_TIME_CONTROL_OFFSET |=>
            low_power_recal_time == $past(reg_wdata[15:10]);
    endproperty
    a_lp_write: assert property (p_lp_write) else $error("low power recal not written");

    property p_irq_set;
        |(st.stage_low_threshold_irq_en & stage_low_event) |=> !int_n;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("enabled event did not assert interrupt");

    property p_irq_masked;
        !(|(st.stage_low_threshold_irq_en & stage_low_event)) |=> int_n;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked event asserted interrupt");

    property p_reset_vals;
        $past(reset) |-> st.stage_low_threshold_irq_en == 12'h000 && full_power_recal_time == 10'h3FF
            && low_power_recal_time == 6'h3F && int_n;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");

    property p_pin_off;
        reg_wr && reg_addr == LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET && !reg_wdata[PIN_FUNC_MSB] |=> !gpio_oe;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled or input");

    property p_pin_drive;
        st.pin_func[1] |-> gpio_oe && (gpio_out == (gpio_assert ~^ st.pin_func[0]));
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("output polarity wrong");

    property p_level;
        st.pin_func == PIN_FUNC_INPUT && st.pin_trig == PIN_TRIG_NEG_LEVEL && !st.pin_sync |=> gpio_event;
    endproperty
    a_level: assert property (p_level) else $error("negative level not seen");

    property p_edge;
        st.pin_func == PIN_FUNC_INPUT && st.pin_trig == PIN_TRIG_POS_EDGE && st.pin_sync && !st.pin_prev
            ##1 st.pin_sync |=> !gpio_event;
    endproperty
    a_edge: assert property (p_edge) else $error("rising edge event longer than one cycle");

    property p_pin_reset;
        $past(reset) |-> st.pin_func == 2'h0 && st.pin_trig == 2'h0 && !gpio_oe;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin setup not cleared by reset");

    property p_en_write;
        reg_wr && reg_addr == LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET |=>
            st.stage_low_threshold_irq_en == $past(reg_wdata[STAGE_EN_MSB:STAGE_EN_LSB]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("stage enables not written");

    property p_setup_write;
        reg_wr && reg_addr == LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET |=>
            {st.pin_trig, st.pin_func} == $past(reg_wdata[PIN_TRIG_MSB:PIN_FUNC_LSB]);
    endproperty
    a_setup_write: assert property (p_setup_write) else $error("pin setup not written");

    property p_read_recal;
        reg_rd && reg_addr == PROXIMITY_RECAL_TIME_CONTROL_OFFSET |=>
            reg_rdata == $past({low_power_recal_time, full_power_recal_time});
    endproperty
    a_read_recal: assert property (p_read_recal) else $error("recal register read back wrong");

    // events only while the pin is an input, else a driven pin would echo itself
    property p_no_event;
        st.pin_func != PIN_FUNC_INPUT |=> !gpio_event;
    endproperty
    a_no_event: assert property (p_no_event) else $error("pin event outside input function");

    property p_pos_level;
        st.pin_func == PIN_FUNC_INPUT && st.pin_trig == PIN_TRIG_POS_LEVEL && st.pin_sync |=> gpio_event;
    endproperty
    a_pos_level: assert property (p_pos_level) else $error("positive level not seen");

    property p_fall_edge;
        st.pin_func == PIN_FUNC_INPUT && st.pin_trig == PIN_TRIG_NEG_EDGE && !st.pin_sync && st.pin_prev
            |=> gpio_event;
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling edge not seen");

    c_irq: cover property (!int_n);
    c_rise: cover property (st.pin_trig == PIN_TRIG_POS_EDGE && gpio_event);
    c_setup_wr: cover property (reg_wr && reg_addr == LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET);
    c_drive: cover property (gpio_oe && gpio_out);
    c_fall: cover property (st.pin_trig == PIN_TRIG_NEG_EDGE && gpio_event);
endmodule : lirq_ctrl
`default_nettype wire

// ### rtl/lirq_pkg.sv
`default_nettype none
package lirq_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_WIDTH = 10;
    localparam int DATA_WIDTH = 16;
    localparam int NUM_STAGES = 12;
    localparam logic [9:0] PROXIMITY_RECAL_TIME_CONTROL_OFFSET = 10'h004;
    localparam logic [9:0] LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET = 10'h005;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int FULL_POWER_RECAL_LSB = 0;
    localparam int FULL_POWER_RECAL_MSB = 9;
    localparam int LOW_POWER_RECAL_LSB = 10;
    localparam int LOW_POWER_RECAL_MSB = 15;
    localparam int STAGE_EN_LSB = 0;
    localparam int STAGE_EN_MSB = 11;
    localparam int PIN_FUNC_LSB = 12;
    localparam int PIN_FUNC_MSB = 13;
    localparam int PIN_TRIG_LSB = 14;
    localparam int PIN_TRIG_MSB = 15;
    localparam logic [9:0] FULL_POWER_RECAL_RESET = 10'h3FF;
    localparam logic [5:0] LOW_POWER_RECAL_RESET = 6'h3F;
    localparam logic [11:0] STAGE_EN_RESET = 12'h000;
    // ----------------------------------------
    // pin function and trigger codes
    // ----------------------------------------
    localparam logic [1:0] PIN_FUNC_DISABLED = 2'h0;
    localparam logic [1:0] PIN_FUNC_INPUT = 2'h1;
    localparam logic [1:0] PIN_FUNC_OUT_LOW = 2'h2;
    localparam logic [1:0] PIN_FUNC_OUT_HIGH = 2'h3;
    localparam logic [1:0] PIN_TRIG_NEG_LEVEL = 2'h0;
    localparam logic [1:0] PIN_TRIG_POS_EDGE = 2'h1;
    localparam logic [1:0] PIN_TRIG_NEG_EDGE = 2'h2;
    localparam logic [1:0] PIN_TRIG_POS_LEVEL = 2'h3;
endpackage : lirq_pkg
`default_nettype wire

// ### sim/lirq_host.sv
`default_nettype none
module lirq_host
    import lirq_pkg::*;
(
    input wire logic clk_sys,
    output logic [ADDR_WIDTH-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic [DATA_WIDTH-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    end
    // ------------------------------
    // host register access
    // ------------------------------
    // released address and data lines show the inverse and both strobes drop low, so a stale copy is never mistaken for data
    task automatic access(input logic wr, input logic [9:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys);
        #1;
        {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, wr, ~wr, d};
        @(posedge clk_sys);
        #1;
        {reg_addr, reg_wr, reg_rd, reg_wdata} = {~a, 2'h0, ~d};
        q = reg_rdata;
    endtask : access
endmodule : lirq_host
`default_nettype wire

// ### sim/low_irq_enable_and_pin_config_test.sv
`default_nettype none
module low_irq_enable_and_pin_config_test
    import lirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] A_RT = PROXIMITY_RECAL_TIME_CONTROL_OFFSET;
    localparam logic [9:0] A_EN = LOW_THRESHOLD_IRQ_ENABLE_AND_PIN_SETUP_OFFSET;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [9:0] reg_addr, fp;
    logic reg_wr, reg_rd, int_n, gpio_out, gpio_oe, gpio_event;
    logic gpio_in = 1'b0;
    logic gpio_assert = 1'b0;
    logic [15:0] reg_wdata, reg_rdata, q, v;
    logic [11:0] en;
    logic [11:0] ev = 12'h000;
    logic [5:0] lp;
    logic [1:0] f;
    int fail_count = 0;
    int n_tests = 0;
    int k, c0, c1;
    `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
        $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
    always #5 clk_sys = ~clk_sys;
    lirq_ctrl dut_u (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stage_low_event(ev), .int_n(int_n),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_assert(gpio_assert),
        .gpio_event(gpio_event), .full_power_recal_time(fp), .low_power_recal_time(lp));
    lirq_host host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic lvl_exp(input logic [1:0] t, input logic in);
        return (t == PIN_TRIG_POS_LEVEL) ? in : ((t == PIN_TRIG_NEG_LEVEL) ? ~in : 1'b0);
    endfunction : lvl_exp
    // two samples still show the old level; the new state shows from the third edge on
    function automatic int cnt_exp(input logic [1:0] t, input logic in);
        if (t == PIN_TRIG_POS_EDGE) return int'(in);
        if (t == PIN_TRIG_NEG_EDGE) return int'(!in);
        return 2 * int'(lvl_exp(t, !in)) + 4 * int'(lvl_exp(t, in));
    endfunction : cnt_exp
    // six cycles covers the two-flop sync plus the event stage
    task automatic pin_step(input logic val, output int cnt);
        gpio_in = val;
        cnt = 0;
        repeat (6) begin
            @(posedge clk_sys);
            #1;
            cnt += int'(gpio_event === 1'b1);
        end
    endtask : pin_step
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h86AAB50A));
        ev = 12'($urandom());
        repeat (20) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        host_u.access(1'b0, A_RT, 16'h0000, q);
        `CHK(q, 16'hFFFF)
        host_u.access(1'b0, A_EN, 16'h0000, q);
        `CHK({q, int_n, gpio_oe, gpio_event}, 19'h00004)
        $display("test reset done");
        for (k = 0; k < 8; k++) begin
            v = (k == 0) ? 16'h0000 : 16'($urandom());
            host_u.access(1'b1, A_RT, v, q);
            host_u.access(1'b0, A_RT, 16'h0000, q);
            `CHK({q, lp, fp}, {v, v})
        end
        host_u.access(1'b1, 10'h3A0, 16'hFFFF, q);
        host_u.access(1'b0, 10'h3A0, 16'h0000, q);
        `CHK({q, lp, fp}, {16'h0000, v})
        $display("test recal done");
        for (k = 0; k < 24; k++) begin
            en = (k == 0) ? 12'hFFF : ((k == 1) ? 12'h000 : 12'($urandom()));
            host_u.access(1'b1, A_EN, {4'h0, en}, q);
            ev = (k == 0) ? 12'h000 : ((k == 1) ? 12'hFFF : 12'($urandom()));
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK(int_n, ~|(en & ev))
            host_u.access(1'b0, A_EN, 16'h0000, q);
            `CHK(q, {PIN_TRIG_NEG_LEVEL, PIN_FUNC_DISABLED, en})
        end
        $display("test irq done");
        gpio_in = 1'b1;
        for (k = 0; k < 8; k++) begin
            f = 2'(k);
            gpio_assert = k[2];
            host_u.access(1'b1, A_EN, {PIN_TRIG_POS_LEVEL, f, 12'h000}, q);
            repeat (4) @(posedge clk_sys);
            #1;
            `CHK(gpio_oe, f[1])
            if (f[1]) `CHK(gpio_out, f[0] ~^ k[2])
            `CHK(gpio_event, f == PIN_FUNC_INPUT)
        end
        $display("test pin function done");
        for (k = 0; k < 4; k++) begin
            host_u.access(1'b1, A_EN, {2'(k), PIN_FUNC_INPUT, 12'h000}, q);
            pin_step(1'b0, c0);
            pin_step(1'b1, c1);
            `CHK({gpio_event, c1}, {lvl_exp(2'(k), 1'b1), cnt_exp(2'(k), 1'b1)})
            pin_step(1'b0, c0);
            `CHK({gpio_event, c0}, {lvl_exp(2'(k), 1'b0), cnt_exp(2'(k), 1'b0)})
        end
        $display("test trigger done");
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        host_u.access(1'b0, A_EN, 16'h0000, q);
        `CHK({q, gpio_oe, fp, lp}, {16'h0000, 1'b0, 10'h3FF, 6'h3F})
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : low_irq_enable_and_pin_config_test
`default_nettype wire
